// ### logic/vmf_pkg.sv
// package: register map, fields, encodings and reset values for vlan fwd
package vmf_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_ARG = 5'h00;
  localparam logic [4:0] OFS_CMD = 5'h04;
  localparam logic [4:0] OFS_MGMT = 5'h08;
  localparam logic [4:0] OFS_QUERY = 5'h0c;
  localparam logic [4:0] OFS_FILTER = 5'h10;

  // ----------------------------------------------------------------
  // argument and status register fields
  // ----------------------------------------------------------------
  localparam int ARG_VID_LSB = 0;
  localparam int ARG_PORT_LSB = 12;
  localparam int ARG_MODE_LSB = 16;
  localparam int ARG_TAG_BIT = 18;
  localparam int ARG_FTYPE_LSB = 19;
  localparam int ARG_PRIO_LSB = 21;
  localparam int STAT_OK_BIT = 0;
  localparam int STAT_ERR_BIT = 1;

  // ----------------------------------------------------------------
  // vid limits, reset values and unmapped read value
  // ----------------------------------------------------------------
  localparam logic [11:0] VID_MIN = 12'h001;
  localparam logic [11:0] VID_MAX = 12'hffe;
  localparam logic [11:0] RST_VID = 12'h001;
  localparam logic [2:0] RST_PRIO = 3'h0;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_FIXED = 2'h1;
  localparam logic [1:0] MODE_FORBID = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [1:0] FT_ALL = 2'h0;
  localparam logic [1:0] FT_TAG = 2'h1;
  localparam logic [1:0] FT_UNTAG = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SET_MEMBER = 3'h1,
    OP_DELETE = 3'h2,
    OP_SET_PVID = 3'h3,
    OP_SET_FTYPE = 3'h4,
    OP_SET_PRIO = 3'h5,
    OP_SET_MGMT = 3'h6
  } vmf_op_t;

endpackage

// ### logic/vmf_vlan_fwd.sv
// vlan membership table, port settings and per-frame forwarding decision
`timescale 1ns/1ps

// Functional notes
// R1: vids accepted only from 1 to 4094
// R2: fixed port is static member with tag flag
// R3: fixed tagged port sends frames with tag
// R4: fixed untagged port sends frames untagged
// R5: forbidden port cannot be vlan member
// R6: normal port registration confirmed, plain member
// R7: no leaving fixed while pvid is vlan
// R8: management vlan exists, keeps one fixed member
// R9: tagged frame vid looked up in table
// R10: port filter applied last, may drop
// R11: untagged frame takes ingress port pvid
// R12: ingress port never in egress set
// R13: never forward to forbidden port
// R14: empty egress set drops, skips filter
// R15: tag-only dsl port drops untagged frames
// R16: untag-only dsl port drops tagged frames
// R17: dsl port set all admits both
// R18: ethernet ports admit both frame kinds
// R19: management only from management vlan members
// R20: reset: management vid 1, all members
// R21: per-port 3-bit priority for tagged frames
// R22: no delete of pvid or management vlan
// R23: each port holds default vid
module vmf_vlan_fwd
  import vmf_pkg::*;
#(
  parameter int NUM_PORTS = 14,
  parameter int NUM_DSL = 12,
  parameter int TABLE_SIZE = 16
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // avalon-mm slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // received frame header
  input wire logic FRM_VALID,
  input wire logic [$clog2(NUM_PORTS)-1:0] FRM_PORT,
  input wire logic FRM_TAGGED,
  input wire logic [11:0] FRM_VID,
  input wire logic FRM_MGMT,
  // forwarding decision
  output logic FWD_VALID,
  output logic [NUM_PORTS-1:0] FWD_EGRESS,
  output logic [NUM_PORTS-1:0] FWD_TAG,
  output logic FWD_DROP,
  output logic [11:0] FWD_VID,
  output logic [2:0] FWD_PRIO,
  output logic FWD_MGMT_OK
);

  localparam int PW = $clog2(NUM_PORTS);
  localparam int IW = $clog2(TABLE_SIZE);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic ent_valid [TABLE_SIZE];
  logic [11:0] ent_vid [TABLE_SIZE];
  logic [NUM_PORTS-1:0] ent_fixed [TABLE_SIZE];
  logic [NUM_PORTS-1:0] ent_forb [TABLE_SIZE];
  logic [NUM_PORTS-1:0] ent_tag [TABLE_SIZE];
  logic [11:0] pvid [NUM_PORTS];
  logic [2:0] prio [NUM_PORTS];
  logic [1:0] ftype [NUM_PORTS];
  logic [NUM_PORTS-1:0] egress_filter;
  logic [11:0] mgmt_vid;
  logic [31:0] arg;
  logic cmd_ok;
  logic cmd_err;

  // table search, used by commands, frames and the management check
  function automatic logic [IW:0] find_vid(input logic [11:0] v);
    logic [IW:0] r;
    r = '0;
    for (int i = TABLE_SIZE - 1; i >= 0; i--) begin
      if (ent_valid[i] && ent_vid[i] == v) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [11:0] arg_vid;
  logic [3:0] arg_port;
  logic [1:0] arg_mode;
  logic [PW-1:0] sel;
  vmf_op_t op;
  logic acc_go, cmd_go, vid_ok, port_ok;
  logic c_hit, free_ok, pvid_uses, next_err;
  logic [IW-1:0] c_idx, free_idx, tgt;
  logic [NUM_PORTS-1:0] new_fixed, new_forb, new_tag;

  assign arg_vid = arg[ARG_VID_LSB +: 12];
  assign arg_port = arg[ARG_PORT_LSB +: 4];
  assign arg_mode = arg[ARG_MODE_LSB +: 2];
  assign sel = PW'(arg_port);
  assign acc_go = AVS_WRITE && !AVS_WAITREQUEST;
  assign cmd_go = acc_go && AVS_ADDRESS == OFS_CMD;
  assign vid_ok = arg_vid >= VID_MIN && arg_vid <= VID_MAX; // R1
  assign port_ok = int'(arg_port) < NUM_PORTS;
  assign tgt = c_hit ? c_idx : free_idx;

  // lookups and the membership that a set command would leave
  always_comb begin
    {c_hit, c_idx} = find_vid(arg_vid);
    free_ok = 1'b0;
    free_idx = '0;
    for (int i = TABLE_SIZE - 1; i >= 0; i--) begin
      if (!ent_valid[i]) begin
        free_ok = 1'b1;
        free_idx = IW'(i);
      end
    end
    pvid_uses = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (pvid[p] == arg_vid) begin
        pvid_uses = 1'b1;
      end
    end
    // a fresh entry starts with every port forbidden
    new_fixed = c_hit ? ent_fixed[c_idx] : '0;
    new_forb = c_hit ? ent_forb[c_idx] : '1;
    new_tag = c_hit ? ent_tag[c_idx] : '0;
    new_fixed[sel] = arg_mode == MODE_FIXED; // R2
    new_forb[sel] = arg_mode == MODE_FORBID; // R5 R6
    new_tag[sel] = arg[ARG_TAG_BIT]; // R2
  end

  // rejection checks per opcode
  always_comb begin
    op = vmf_op_t'(AVS_WRITEDATA[2:0]);
    case (op)
      OP_SET_MEMBER: begin
        next_err = !vid_ok || !port_ok || arg_mode == 2'h0 // R1
          || (!c_hit && !free_ok)
          || (c_hit && ent_fixed[c_idx][sel] && arg_mode != MODE_FIXED
              && pvid[sel] == arg_vid) // R7
          || (arg_vid == mgmt_vid && new_fixed == '0); // R8
      end
      OP_DELETE: begin
        next_err = !vid_ok || !c_hit || arg_vid == mgmt_vid // R22
          || pvid_uses; // R22
      end
      OP_SET_PVID: begin
        next_err = !vid_ok || !port_ok || !c_hit // R1 R23
          || !ent_fixed[c_idx][sel];
      end
      OP_SET_FTYPE: begin
        next_err = !port_ok || int'(arg_port) >= NUM_DSL
          || arg[ARG_FTYPE_LSB +: 2] == 2'h3;
      end
      OP_SET_PRIO: begin
        next_err = !port_ok;
      end
      OP_SET_MGMT: begin
        next_err = !vid_ok || !c_hit || ent_fixed[c_idx] == '0; // R8
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // static vlan table
  // ----------------------------------------------------------------
  // entry 0 holds vid 1 with every port fixed and untagged
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < TABLE_SIZE; i++) begin
        ent_valid[i] <= i == 0; // R20
        ent_vid[i] <= RST_VID; // R20
        ent_fixed[i] <= i == 0 ? '1 : '0;
        ent_forb[i] <= '0;
        ent_tag[i] <= '0;
      end
    end else if (cmd_go && !next_err) begin
      if (op == OP_SET_MEMBER) begin
        ent_valid[tgt] <= 1'b1;
        ent_vid[tgt] <= arg_vid;
        ent_fixed[tgt] <= new_fixed; // R2
        ent_forb[tgt] <= new_forb; // R5
        ent_tag[tgt] <= new_tag;
      end else if (op == OP_DELETE) begin
        ent_valid[c_idx] <= 1'b0; // R22
      end
    end
  end

  // ----------------------------------------------------------------
  // per-port settings
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        pvid[p] <= RST_VID; // R20
        prio[p] <= RST_PRIO;
        ftype[p] <= FT_ALL;
      end
    end else if (cmd_go && !next_err) begin
      if (op == OP_SET_PVID) begin
        pvid[sel] <= arg_vid; // R23
      end else if (op == OP_SET_PRIO) begin
        prio[sel] <= arg[ARG_PRIO_LSB +: 3]; // R21
      end else if (op == OP_SET_FTYPE) begin
        ftype[sel] <= arg[ARG_FTYPE_LSB +: 2];
      end
    end
  end

  // management vid, argument word, filter and command status
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mgmt_vid <= RST_VID; // R20
      arg <= '0;
      egress_filter <= '1;
      cmd_ok <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      if (cmd_go && !next_err && op == OP_SET_MGMT) begin
        mgmt_vid <= arg_vid; // R8
      end
      if (acc_go && AVS_ADDRESS == OFS_ARG) begin
        arg <= AVS_WRITEDATA;
      end
      if (acc_go && AVS_ADDRESS == OFS_FILTER) begin
        egress_filter <= AVS_WRITEDATA[NUM_PORTS-1:0]; // R10
      end
      if (cmd_go) begin
        cmd_ok <= !next_err;
        cmd_err <= next_err;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus handshake and read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [1:0] q_mode;

  // read data come from the register map at the bus address; the query word at the selected port
  always_comb begin
    if (ent_fixed[c_idx][sel]) begin
      q_mode = MODE_FIXED;
    end else if (ent_forb[c_idx][sel]) begin
      q_mode = MODE_FORBID;
    end else begin
      q_mode = MODE_NORMAL;
    end
    if (AVS_ADDRESS == OFS_ARG) begin
      next_rdata = arg;
    end else if (AVS_ADDRESS == OFS_CMD) begin
      next_rdata = 32'({cmd_err, cmd_ok});
    end else if (AVS_ADDRESS == OFS_MGMT) begin
      next_rdata = 32'(mgmt_vid);
    end else if (AVS_ADDRESS == OFS_QUERY) begin
      next_rdata = 32'({ftype[sel], prio[sel], pvid[sel],
                        ent_tag[c_idx][sel], q_mode, c_hit});
    end else if (AVS_ADDRESS == OFS_FILTER) begin
      next_rdata = 32'(egress_filter);
    end else begin
      next_rdata = RD_UNMAPPED;
    end
  end

  // one wait cycle per access keeps decode off the request edge
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST) begin
        AVS_READDATA <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // forwarding decision
  // ----------------------------------------------------------------
  logic [11:0] in_pvid, f_vid;
  logic admit, f_hit, m_hit, mgmt_member;
  logic [IW-1:0] f_idx, m_idx;
  logic [NUM_PORTS-1:0] vlan_set, no_tag_ok, final_set;

  always_comb begin
    in_pvid = pvid[FRM_PORT];
    f_vid = FRM_TAGGED ? FRM_VID : in_pvid; // R11
    admit = 1'b1; // R18
    if (int'(FRM_PORT) < NUM_DSL) begin
      case (ftype[FRM_PORT])
        FT_TAG: admit = FRM_TAGGED; // R15
        FT_UNTAG: admit = !FRM_TAGGED; // R16
        default: admit = 1'b1; // R17
      endcase
    end
    {f_hit, f_idx} = find_vid(f_vid); // R9
    {m_hit, m_idx} = find_vid(mgmt_vid);
    // fixed and normal ports are members, forbidden never
    vlan_set = f_hit ? ~ent_forb[f_idx] : '0; // R13 R6
    vlan_set[FRM_PORT] = 1'b0; // R12
    for (int p = 0; p < NUM_PORTS; p++) begin
      // subscriber equipment on untag-only ports refuses tags
      no_tag_ok[p] = p < NUM_DSL && ftype[p] == FT_UNTAG
        && ent_tag[f_idx][p];
    end
    final_set = '0;
    if (admit && f_vid >= VID_MIN && f_vid <= VID_MAX
        && vlan_set != '0) begin // R14
      final_set = vlan_set & egress_filter & ~no_tag_ok; // R10
    end
    mgmt_member = m_hit && !ent_forb[m_idx][FRM_PORT]; // R19
  end

  // decision registered one cycle after the header
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FWD_VALID <= 1'b0;
      FWD_EGRESS <= '0;
      FWD_TAG <= '0;
      FWD_DROP <= 1'b0;
      FWD_VID <= '0;
      FWD_PRIO <= '0;
      FWD_MGMT_OK <= 1'b0;
    end else begin
      FWD_VALID <= FRM_VALID;
      FWD_EGRESS <= FRM_VALID ? final_set : '0;
      FWD_TAG <= FRM_VALID ? final_set & ent_tag[f_idx] : '0; // R3 R4
      FWD_DROP <= FRM_VALID && final_set == '0;
      FWD_VID <= f_vid;
      FWD_PRIO <= FRM_TAGGED ? prio[FRM_PORT] : RST_PRIO; // R21
      FWD_MGMT_OK <= FRM_VALID && FRM_MGMT && admit && mgmt_member;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  a_ingress_excluded: assert property ( // R12
    FRM_VALID |=> !FWD_EGRESS[$past(FRM_PORT)])
    else $error("frame sent back to its ingress port");
  a_empty_drops: assert property ( // R14
    FWD_VALID && FWD_EGRESS == '0 |-> FWD_DROP)
    else $error("empty egress set not dropped");
  a_pvid_assign: assert property ( // R11
    FRM_VALID && !FRM_TAGGED |=> FWD_VID == $past(in_pvid))
    else $error("untagged frame did not take port default vid");
  a_tagonly_drop: assert property ( // R15
    FRM_VALID && !FRM_TAGGED && int'(FRM_PORT) < NUM_DSL
    && ftype[FRM_PORT] == FT_TAG |=> FWD_DROP)
    else $error("untagged frame passed a tag-only port");
  a_untagonly_drop: assert property ( // R16
    FRM_VALID && FRM_TAGGED && int'(FRM_PORT) < NUM_DSL
    && ftype[FRM_PORT] == FT_UNTAG |=> FWD_DROP)
    else $error("tagged frame passed an untag-only port");
  a_forbid_blocked: assert property ( // R13
    FRM_VALID && f_hit |=> (FWD_EGRESS & $past(ent_forb[f_idx])) == '0)
    else $error("frame forwarded to a forbidden port");
  a_vid_range: assert property ( // R1
    cmd_go && (arg_vid == 12'h000 || arg_vid == 12'hfff)
    && op != OP_SET_PRIO && op != OP_SET_FTYPE |=> cmd_err)
    else $error("out of range vid accepted");
  a_mgmt_fixed: assert property ( // R8
    m_hit && ent_fixed[m_idx] != '0)
    else $error("management vlan lost or has no fixed member");
  a_tagged_prio: assert property ( // R21
    FRM_VALID && FRM_TAGGED |=> FWD_PRIO == $past(prio[FRM_PORT]))
    else $error("tagged frame priority not from ingress port");
  a_pvid_hold: assert property ( // R7
    cmd_go && op == OP_SET_MEMBER && c_hit && ent_fixed[c_idx][sel]
    && arg_mode != MODE_FIXED && pvid[sel] == arg_vid |=> cmd_err)
    else $error("fixed port left the vlan of its default vid");

  c_forwarded: cover property (FWD_VALID && !FWD_DROP && FWD_TAG != '0);
  c_dropped: cover property (FWD_VALID && FWD_DROP);
  c_refused: cover property (cmd_go ##1 cmd_err);
  c_mgmt: cover property (FWD_MGMT_OK);

endmodule // vmf_vlan_fwd

// ### verification/vmf_port_model.sv
// port side model: presents received frame headers to the block
`timescale 1ns/1ps
module vmf_port_model #(
  parameter int NUM_PORTS = 14
) (
  // clock
  input wire logic core_clk,
  // frame header toward the block
  output logic frm_valid,
  output logic [$clog2(NUM_PORTS)-1:0] frm_port,
  output logic frm_tagged,
  output logic [11:0] frm_vid,
  output logic frm_mgmt
);
  // ----------------------------------------------------------------
  // idle state and header task
  // ----------------------------------------------------------------
  // idle values at time zero
  initial begin
    frm_valid = 1'b0;
    frm_port = '0;
    frm_tagged = 1'b0;
    frm_vid = 12'h000;
    frm_mgmt = 1'b0;
  end

  // one-cycle header; fields are inverted after release so that a
  // stale header never passes for a fresh one
  task automatic send(input logic [$clog2(NUM_PORTS)-1:0] p,
    input logic t, input logic [11:0] v, input logic m);
    frm_port <= p;
    frm_tagged <= t;
    frm_vid <= v;
    frm_mgmt <= m;
    frm_valid <= 1'b1;
    @(posedge core_clk);
    frm_valid <= 1'b0;
    frm_port <= ~p;
    frm_tagged <= ~t;
    frm_vid <= ~v;
    frm_mgmt <= ~m;
  endtask
endmodule // vmf_port_model

// ### verification/testbench.sv
// self-checking bench for the vlan forwarding block
`timescale 1ns/1ps
module testbench
  import vmf_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk;
  logic reset_n;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic frm_valid;
  logic [3:0] frm_port;
  logic frm_tagged;
  logic [11:0] frm_vid;
  logic frm_mgmt;
  logic fwd_valid;
  logic [13:0] fwd_egress;
  logic [13:0] fwd_tag;
  logic fwd_drop;
  logic [11:0] fwd_vid;
  logic [2:0] fwd_prio;
  logic fwd_mgmt_ok;
  int failures = 0;
  int checked = 0;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  vmf_vlan_fwd #(.NUM_PORTS(14), .NUM_DSL(12), .TABLE_SIZE(16)) i_dut (
    .CORE_CLK(core_clk), .RESET_N(reset_n),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .FRM_VALID(frm_valid), .FRM_PORT(frm_port),
    .FRM_TAGGED(frm_tagged), .FRM_VID(frm_vid), .FRM_MGMT(frm_mgmt),
    .FWD_VALID(fwd_valid), .FWD_EGRESS(fwd_egress), .FWD_TAG(fwd_tag),
    .FWD_DROP(fwd_drop), .FWD_VID(fwd_vid), .FWD_PRIO(fwd_prio),
    .FWD_MGMT_OK(fwd_mgmt_ok));

  vmf_port_model #(.NUM_PORTS(14)) i_src (
    .core_clk(core_clk), .frm_valid(frm_valid), .frm_port(frm_port),
    .frm_tagged(frm_tagged), .frm_vid(frm_vid), .frm_mgmt(frm_mgmt));

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_fwd(input logic [45:0] got, input logic [45:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer; the slave timing is never assumed, only awaited
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 100) failures++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk_reg(q, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // argument then opcode, then status: 1 applied, 2 refused
  task automatic cmd(input logic [2:0] op, input logic [11:0] v,
    input logic [3:0] p, input logic [7:0] f, input int ok);
    wr(OFS_ARG, {8'h00, f, p, v});
    wr(OFS_CMD, {29'h0, op});
    rd(OFS_CMD, ok != 0 ? 32'h0000_0001 : 32'h0000_0002);
  endtask

  // header in, decision one cycle later
  task automatic frm(input logic [3:0] p, input int t,
    input logic [11:0] v, input int m, input logic [13:0] eg,
    input logic [13:0] tg, input logic [11:0] ev, input logic [2:0] pr,
    input int ok);
    i_src.send(p, 1'(t), v, 1'(m));
    @(posedge core_clk);
    chk_fwd({fwd_valid, fwd_drop, fwd_mgmt_ok, fwd_prio, fwd_vid, fwd_tag,
      fwd_egress}, {1'b1, eg == 14'h0, 1'(ok), pr, ev, tg, eg});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    rd(OFS_MGMT, 32'h0000_0001);
    rd(OFS_FILTER, 32'h0000_3fff);
    frm(4'd0, 0, 12'h123, 1, 14'h3ffe, 14'h0, 12'h001, 3'h0, 1);
    frm(4'd13, 1, 12'h001, 0, 14'h1fff, 14'h0, 12'h001, 3'h0, 0);
  endtask

  task automatic s_member();
    cmd(OP_SET_MEMBER, 12'h005, 4'd12, 8'h05, 1);
    cmd(OP_SET_MEMBER, 12'h005, 4'd3, 8'h01, 1);
    cmd(OP_SET_MEMBER, 12'h005, 4'd4, 8'h03, 1);
    frm(4'd3, 1, 12'h005, 0, 14'h1010, 14'h1000, 12'h005, 3'h0, 0);
    frm(4'd12, 1, 12'h005, 0, 14'h0018, 14'h0, 12'h005, 3'h0, 0);
    cmd(OP_SET_MEMBER, 12'h005, 4'd4, 8'h02, 1);
    frm(4'd12, 1, 12'h005, 0, 14'h0008, 14'h0, 12'h005, 3'h0, 0);
  endtask

  task automatic s_refuse();
    cmd(OP_SET_MEMBER, 12'h000, 4'd1, 8'h01, 0);
    cmd(OP_SET_MEMBER, 12'hfff, 4'd1, 8'h01, 0);
    cmd(OP_SET_PVID, 12'h005, 4'd3, 8'h00, 1);
    frm(4'd3, 0, 12'h007, 0, 14'h1000, 14'h1000, 12'h005, 3'h0, 0);
    cmd(OP_SET_MEMBER, 12'h005, 4'd3, 8'h03, 0);
    cmd(OP_DELETE, 12'h005, 4'd0, 8'h00, 0);
    cmd(OP_DELETE, 12'h001, 4'd0, 8'h00, 0);
    cmd(3'h7, 12'h005, 4'd1, 8'h01, 0);
  endtask

  task automatic s_ftype();
    cmd(OP_SET_FTYPE, 12'h001, 4'd3, 8'h08, 1);
    frm(4'd3, 0, 12'h007, 0, 14'h0, 14'h0, 12'h005, 3'h0, 0);
    frm(4'd3, 1, 12'h005, 0, 14'h1000, 14'h1000, 12'h005, 3'h0, 0);
    cmd(OP_SET_FTYPE, 12'h001, 4'd3, 8'h10, 1);
    frm(4'd3, 1, 12'h005, 0, 14'h0, 14'h0, 12'h005, 3'h0, 0);
    frm(4'd3, 0, 12'h007, 0, 14'h1000, 14'h1000, 12'h005, 3'h0, 0);
    cmd(OP_SET_MEMBER, 12'h007, 4'd3, 8'h05, 1);
    cmd(OP_SET_MEMBER, 12'h007, 4'd13, 8'h01, 1);
    frm(4'd13, 1, 12'h007, 0, 14'h0, 14'h0, 12'h007, 3'h0, 0);
    cmd(OP_SET_FTYPE, 12'h001, 4'd3, 8'h00, 1);
    frm(4'd13, 1, 12'h007, 0, 14'h0008, 14'h0008, 12'h007, 3'h0, 0);
    frm(4'd3, 1, 12'h005, 0, 14'h1000, 14'h1000, 12'h005, 3'h0, 0);
    cmd(OP_SET_FTYPE, 12'h001, 4'd12, 8'h08, 0);
    frm(4'd12, 0, 12'h009, 0, 14'h2fff, 14'h0, 12'h001, 3'h0, 0);
  endtask

  task automatic s_filter();
    wr(OFS_FILTER, 32'h0000_2fff);
    rd(OFS_FILTER, 32'h0000_2fff);
    frm(4'd13, 0, 12'h009, 0, 14'h0fff, 14'h0, 12'h001, 3'h0, 0);
    wr(OFS_FILTER, 32'h0000_3fff);
    frm(4'd13, 1, 12'h009, 0, 14'h0, 14'h0, 12'h009, 3'h0, 0);
    rd(5'h14, RD_UNMAPPED);
  endtask

  task automatic s_prio();
    cmd(OP_SET_PRIO, 12'h001, 4'd12, 8'he0, 1);
    // query vid 5 at port 12: found, fixed, tagged, pvid 1, prio 7
    wr(OFS_ARG, 32'h0000_c005);
    rd(OFS_QUERY, 32'h0007_001b);
    frm(4'd12, 1, 12'h005, 0, 14'h0008, 14'h0, 12'h005, 3'h7, 0);
    frm(4'd12, 0, 12'h005, 0, 14'h2fff, 14'h0, 12'h001, 3'h0, 0);
  endtask

  // management moves to vid 7, then port 13 must stay its fixed member
  task automatic s_mgmt();
    cmd(OP_SET_MGMT, 12'h009, 4'd0, 8'h00, 0);
    cmd(OP_SET_MEMBER, 12'h008, 4'd4, 8'h03, 1);
    cmd(OP_SET_MGMT, 12'h008, 4'd0, 8'h00, 0);
    cmd(OP_SET_MGMT, 12'h007, 4'd0, 8'h00, 1);
    rd(OFS_MGMT, 32'h0000_0007);
    cmd(OP_SET_MEMBER, 12'h007, 4'd3, 8'h02, 1);
    cmd(OP_SET_MEMBER, 12'h007, 4'd13, 8'h02, 0);
    frm(4'd0, 0, 12'h007, 1, 14'h3ffe, 14'h0, 12'h001, 3'h0, 0);
    frm(4'd13, 1, 12'h007, 1, 14'h0, 14'h0, 12'h007, 3'h0, 1);
    // vid 8 is neither a pvid nor management, so it may go
    cmd(OP_DELETE, 12'h008, 4'd0, 8'h00, 1);
    frm(4'd13, 1, 12'h008, 0, 14'h0, 14'h0, 12'h008, 3'h0, 0);
  endtask

  // ----------------------------------------------------------------
  // verdict, clock, watchdog, main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // the run needs well under a thousand cycles; this cuts off a hang
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    print_verdict();
  end

  // reset for 12 cycles, then the scenarios
  initial begin
    reset_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    s_reset();
    s_member();
    s_refuse();
    s_ftype();
    s_filter();
    s_prio();
    s_mgmt();
    print_verdict();
  end
endmodule // testbench
